// File: core/tv_out_pkg.sv
// constants and types shared by the tv encoder output port
// ==========================================================
package tv_out_pkg;
   // ==========================================================
   // widths and video geometry defaults
   localparam int COMP_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int LINE_LEN = 1716;
   localparam int ACTIVE_START = 276;
   localparam int LINES_PER_FIELD = 262;
   localparam int VS_LEN = 3;
   localparam int EVEN_VS_OFFSET = 858;
   localparam int DATA_LSB = 10;
   localparam int DATA_MSB = 17;
   // ==========================================================
   // pixel clock: received from the video pll, sampled and re-driven by the port
   localparam int PIX_FREQ_KHZ = 27000;
   localparam logic [7:0] IDLE_BYTE = 8'h80;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_HOLD = 3'b100
   } run_state_t;
endpackage : tv_out_pkg

// File: core/tv_fifo.sv
// small valid/ready fifo sitting in the component path
`timescale 1ns/1ps
module tv_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("tv_fifo depth must be a power of two >= 2");
   end
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic push, pop;

   assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
   assign out_valid = wr_ff != rd_ff;
   assign out_data = mem_ff[rd_ff[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
      if (push) begin
         mem_ff[wr_ff[AW-1:0]] <= in_data;
      end
   end
endmodule : tv_fifo

// File: core/tv_encoder_out.sv
// tv encoder video output port: pixel clock, syncs and component byte stream
`timescale 1ns/1ps
module tv_encoder_out
   import tv_out_pkg::*;
#(
   parameter int LINE_CYCLES = LINE_LEN,
   parameter int ACTIVE_FROM = ACTIVE_START,
   parameter int FIELD_LINES = LINES_PER_FIELD,
   parameter int VSYNC_CYCLES = VS_LEN,
   parameter int EVEN_OFFSET = EVEN_VS_OFFSET
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // pixel clock from the video pll, 27 MHz
   input wire logic tv_clk_src,
   // control
   input wire logic enable,
   // component stream in
   input wire logic comp_valid,
   output logic comp_ready,
   input wire logic [COMP_W-1:0] comp_data,
   // encoder pins
   output logic tv_pixel_clock,
   output logic tv_line_sync_n,
   output logic tv_field_sync_n,
   output logic tv_data_valid_n,
   output logic [DATA_MSB:DATA_LSB] display_data_upper_byte,
   // status
   output logic underrun,
   output logic odd_field
);
   initial begin
      if (ACTIVE_FROM < 1 || ACTIVE_FROM >= LINE_CYCLES) $error("active start out of line");
      if (EVEN_OFFSET < 1 || EVEN_OFFSET >= LINE_CYCLES) $error("even field offset out of line");
      if (VSYNC_CYCLES < 1 || VSYNC_CYCLES > LINE_CYCLES - EVEN_OFFSET) $error("bad field sync length");
      if (FIELD_LINES < 2) $error("field too short");
      if (LINE_CYCLES > 65536 || FIELD_LINES > 65536) $error("counts exceed the 16-bit counters");
   end

   // ==========================================================
   // pixel clock sampling: two flops, then edge detect on the second stage onward
   // the source is sampled, never used as a clock, so the port stays in the mclk domain;
   // limitation: mclk must run above twice the pixel rate or pixel edges are lost
   logic sync1_ff, sync2_ff, sync3_ff;
   logic pix_fall;
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
      end else begin
         sync1_ff <= tv_clk_src;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end
   assign pix_fall = !sync2_ff && sync3_ff;

   // ==========================================================
   // fifo in the component path
   // four bytes absorb the gap between producer bursts and the paced pixel slots
   logic fifo_valid, fifo_ready;
   logic [COMP_W-1:0] fifo_data;
   tv_fifo #(.WIDTH(COMP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .in_valid(comp_valid),
      .in_ready(comp_ready),
      .in_data(comp_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   // wraps to zero at lim, so the column and row counters need no wrap compare of their own
   function automatic logic [15:0] wrap_inc(input logic [15:0] v, input int lim);
      wrap_inc = (int'(v) + 1 >= lim) ? 16'h0000 : v + 16'h0001;
   endfunction : wrap_inc

   // ==========================================================
   // timing state
   // 16-bit counters cover any broadcast raster; the start-up check refuses larger ones
   run_state_t st_ff, nxt_st;
   logic [15:0] col_ff, nxt_col, row_ff, nxt_row;
   logic odd_ff, nxt_odd;
   logic [15:0] vs_cnt_ff, nxt_vs_cnt;
   logic hs_ff, nxt_hs, vs_ff, nxt_vs, dv_ff, nxt_dv;
   logic [COMP_W-1:0] dat_ff, nxt_dat;
   logic pclk_ff, nxt_pclk, und_ff, nxt_und;
   logic active, last_col, last_row;

   assign last_col = int'(col_ff) == LINE_CYCLES - 1;
   assign last_row = int'(row_ff) == FIELD_LINES - 1;
   assign active = int'(col_ff) >= ACTIVE_FROM;
   // a byte is consumed only when the pixel slot is active and the fifo has one
   assign fifo_ready = (st_ff == ST_RUN) && pix_fall && active && !last_col && fifo_valid;

   always_comb begin
      nxt_st = st_ff;
      nxt_col = col_ff;
      nxt_row = row_ff;
      nxt_odd = odd_ff;
      nxt_vs_cnt = vs_cnt_ff;
      nxt_hs = hs_ff;
      nxt_vs = vs_ff;
      nxt_dv = dv_ff;
      nxt_dat = dat_ff;
      nxt_und = 1'b0;
      nxt_pclk = sync2_ff;
      case (st_ff)
         ST_IDLE: begin
            // idle keeps every strobe deasserted and the bus at the blank level
            nxt_hs = 1'b1;
            nxt_vs = 1'b1;
            nxt_dv = 1'b1;
            nxt_dat = IDLE_BYTE;
            if (enable && pix_fall) begin
               // first row of an odd field: both syncs fall together
               nxt_st = ST_RUN;
               nxt_col = '0;
               nxt_row = '0;
               nxt_odd = 1'b1;
               nxt_hs = 1'b0;
               nxt_vs = 1'b0;
               nxt_vs_cnt = 16'(VSYNC_CYCLES - 1);
            end
         end
         ST_RUN: begin
            if (pix_fall) begin
               // outputs change on the falling pixel edge so the encoder samples on the rise
               nxt_col = wrap_inc(col_ff, LINE_CYCLES);
               nxt_hs = !last_col;
               if (vs_cnt_ff != '0) begin
                  nxt_vs_cnt = vs_cnt_ff - 16'h0001;
               end else begin
                  nxt_vs = 1'b1;
               end
               if (last_col) begin
                  nxt_row = wrap_inc(row_ff, FIELD_LINES);
                  if (last_row && !odd_ff) begin
                     nxt_odd = 1'b1;
                     nxt_vs = 1'b0;
                     nxt_vs_cnt = 16'(VSYNC_CYCLES - 1);
                  end
               end
               if (last_row && odd_ff && int'(col_ff) == EVEN_OFFSET - 1) begin
                  // mid-line field sync keeps the even field edge away from line sync
                  nxt_odd = 1'b0;
                  // rows count afresh, or the odd-field test at the end of this very line fires at once
                  nxt_row = '0;
                  nxt_vs = 1'b0;
                  nxt_vs_cnt = 16'(VSYNC_CYCLES - 1);
               end
               // an active slot that finds the fifo empty goes out blank and is flagged
               if (!last_col && active) begin
                  nxt_dv = !fifo_valid;
                  nxt_dat = fifo_valid ? fifo_data : IDLE_BYTE;
                  nxt_und = !fifo_valid;
               end else begin
                  nxt_dv = 1'b1;
                  nxt_dat = IDLE_BYTE;
               end
               if (!enable && last_col && last_row) begin
                  nxt_st = ST_HOLD;
               end
            end
         end
         ST_HOLD: begin
            // let the last line sync pulse finish before going quiet
            if (pix_fall) begin
               nxt_st = ST_IDLE;
               nxt_hs = 1'b1;
               nxt_vs = 1'b1;
               nxt_dv = 1'b1;
            end
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st_ff <= ST_IDLE;
         col_ff <= '0;
         row_ff <= '0;
         odd_ff <= 1'b0;
         vs_cnt_ff <= '0;
         hs_ff <= 1'b1;
         vs_ff <= 1'b1;
         dv_ff <= 1'b1;
         dat_ff <= IDLE_BYTE;
         pclk_ff <= 1'b0;
         und_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         col_ff <= nxt_col;
         row_ff <= nxt_row;
         odd_ff <= nxt_odd;
         vs_cnt_ff <= nxt_vs_cnt;
         hs_ff <= nxt_hs;
         vs_ff <= nxt_vs;
         dv_ff <= nxt_dv;
         dat_ff <= nxt_dat;
         pclk_ff <= nxt_pclk;
         und_ff <= nxt_und;
      end
   end

   // ==========================================================
   // pins
   assign tv_pixel_clock = pclk_ff;
   assign tv_line_sync_n = hs_ff;
   assign tv_field_sync_n = vs_ff;
   assign tv_data_valid_n = dv_ff;
   assign display_data_upper_byte = dat_ff;
   assign underrun = und_ff;
   assign odd_field = odd_ff;
endmodule : tv_encoder_out

// File: bench/tv_encoder_out_chk.sv
// pin-level checker for the tv encoder output port
`timescale 1ns/1ps
module tv_encoder_out_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // encoder pins
   input wire logic tv_pixel_clock,
   input wire logic tv_line_sync_n,
   input wire logic tv_field_sync_n,
   input wire logic tv_data_valid_n,
   input wire logic [17:10] display_data_upper_byte,
   // status
   input wire logic underrun
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // widths assume a pixel of 8 mclk; the synchroniser adds one cycle of jitter
   sequence line_pulse_s;
      !tv_line_sync_n[*6] ##[1:4] tv_line_sync_n;
   endsequence
   sequence pix_high_s;
      tv_pixel_clock[*3] ##[1:3] !tv_pixel_clock;
   endsequence
   line_pulse_a: assert property ($fell(tv_line_sync_n) |-> line_pulse_s)
      else $error("line sync low width wrong");
   field_pulse_a: assert property ($fell(tv_field_sync_n) |-> !tv_field_sync_n[*6])
      else $error("field sync low too short");
   pix_clock_a: assert property ($rose(tv_pixel_clock) |-> pix_high_s)
      else $error("pixel clock high width wrong");
   data_blank_a: assert property (!tv_data_valid_n |-> tv_line_sync_n)
      else $error("data valid during line sync");
   valid_stands_a: assert property ($changed(tv_data_valid_n) |=> $stable(tv_data_valid_n)[*6])
      else $error("data valid changed within a pixel");
   data_stands_a: assert property ($changed(display_data_upper_byte) |=> $stable(display_data_upper_byte)[*6])
      else $error("data changed within a pixel");
   underrun_pulse_a: assert property (underrun |=> !underrun)
      else $error("underrun longer than one cycle");
   underrun_idle_a: assert property (underrun |-> tv_data_valid_n)
      else $error("data valid with underrun");
   reset_idle_a: assert property (disable iff (1'b0) !rstn |=> tv_line_sync_n && tv_field_sync_n
      && tv_data_valid_n && !underrun && display_data_upper_byte == 8'h80)
      else $error("outputs not idle after reset");
endmodule : tv_encoder_out_chk

bind tv_encoder_out tv_encoder_out_chk i_tv_encoder_out_chk (.mclk(mclk), .rstn(rstn),
   .tv_pixel_clock(tv_pixel_clock), .tv_line_sync_n(tv_line_sync_n), .tv_field_sync_n(tv_field_sync_n),
   .tv_data_valid_n(tv_data_valid_n), .display_data_upper_byte(display_data_upper_byte), .underrun(underrun));

// File: bench/tv_encoder_model.sv
// receiving tv encoder: captures bytes and classifies field starts
`timescale 1ns/1ps
module tv_encoder_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // encoder pins
   input wire logic tv_pixel_clock,
   input wire logic tv_line_sync_n,
   input wire logic tv_field_sync_n,
   input wire logic tv_data_valid_n,
   input wire logic [17:10] display_data_upper_byte
);
   logic [7:0] rxq[$];
   int odd_cnt = 0;
   int even_cnt = 0;
   logic pc_q = 1'b0;
   logic ls_q = 1'b1;
   logic fs_q = 1'b1;
   // ==========================================
   // sample on the pixel rise, half a pixel away from where the port updates
   always @(posedge mclk) begin
      pc_q <= tv_pixel_clock;
      if (!rstn) begin
         ls_q <= 1'b1;
         fs_q <= 1'b1;
      end else if (tv_pixel_clock && !pc_q) begin
         ls_q <= tv_line_sync_n;
         fs_q <= tv_field_sync_n;
         if (!tv_data_valid_n) rxq.push_back(display_data_upper_byte);
         if (fs_q && !tv_field_sync_n) begin
            if (ls_q && !tv_line_sync_n) odd_cnt++;
            else even_cnt++;
         end
      end
   end
endmodule : tv_encoder_model

// File: bench/tv_encoder_out_bench.sv
// self-checking bench for the tv encoder output port
`timescale 1ns/1ps
module tv_encoder_out_bench;
   import tv_out_pkg::*;
   logic mclk = 0, rstn = 0, tv_clk_src = 0, enable = 0, comp_valid = 0;
   logic [COMP_W-1:0] comp_data = 8'h00;
   logic comp_ready, tv_pixel_clock, tv_line_sync_n, tv_field_sync_n, tv_data_valid_n, underrun, odd_field;
   logic [DATA_MSB:DATA_LSB] display_data_upper_byte;
   logic [7:0] sent[$];
   int n_errors = 0, checks = 0, cyc = 0;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
   always #20 mclk = ~mclk;
   always #160 tv_clk_src = ~tv_clk_src;
   tv_encoder_out #(.LINE_CYCLES(20), .ACTIVE_FROM(6), .FIELD_LINES(4), .VSYNC_CYCLES(2), .EVEN_OFFSET(10))
   i_tv_encoder_out (.mclk(mclk), .rstn(rstn), .tv_clk_src(tv_clk_src), .enable(enable),
      .comp_valid(comp_valid), .comp_ready(comp_ready), .comp_data(comp_data),
      .tv_pixel_clock(tv_pixel_clock), .tv_line_sync_n(tv_line_sync_n), .tv_field_sync_n(tv_field_sync_n),
      .tv_data_valid_n(tv_data_valid_n), .display_data_upper_byte(display_data_upper_byte),
      .underrun(underrun), .odd_field(odd_field));
   tv_encoder_model i_tv_encoder_model (.mclk(mclk), .rstn(rstn), .tv_pixel_clock(tv_pixel_clock),
      .tv_line_sync_n(tv_line_sync_n), .tv_field_sync_n(tv_field_sync_n), .tv_data_valid_n(tv_data_valid_n),
      .display_data_upper_byte(display_data_upper_byte));
   // ==========================================
   task wrap_up;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   // valid stays up between bytes so back-to-back pushes never double-drive it
   task push(input logic [7:0] b);
      logic ok;
      comp_valid = 1'b1;
      comp_data = b;
      do begin
         ok = comp_ready;
         @(posedge mclk);
         #2;
      end while (ok !== 1'b1);
      sent.push_back(b);
   endtask : push
   task t_reset;
      `CHK("line idle", 1'b1, tv_line_sync_n)
      `CHK("field idle", 1'b1, tv_field_sync_n)
      `CHK("valid idle", 1'b1, tv_data_valid_n)
      `CHK("data idle", 8'h80, display_data_upper_byte)
      `CHK("underrun idle", 1'b0, underrun)
      $display("t_reset done");
   endtask : t_reset
   task t_fill_stream;
      int n;
      logic seen;
      push(8'h01);
      push(8'h80);
      push(8'hA5);
      push(8'h3C);
      comp_data = 8'h5A;
      `CHK("full refuses", 1'b0, comp_ready)
      enable = 1'b1;
      for (int i = 0; i < 8; i++) push(8'h11 * i[7:0] + 8'h5A);
      comp_valid = 1'b0;
      n = 0;
      while (i_tv_encoder_model.rxq.size() < sent.size() && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      `CHK("rx count", sent.size(), i_tv_encoder_model.rxq.size())
      foreach (sent[i]) `CHK("rx byte", sent[i], i_tv_encoder_model.rxq[i])
      seen = 1'b0;
      for (int i = 0; i < 400 && !seen; i++) begin
         @(posedge mclk);
         #2;
         seen = underrun;
      end
      `CHK("underrun on empty", 1'b1, seen)
      $display("t_fill_stream done");
   endtask : t_fill_stream
   task t_fields;
      logic quiet;
      for (int i = 0; i < 4000 && i_tv_encoder_model.odd_cnt < 2; i++) @(posedge mclk);
      #2;
      `CHK("odd starts", 1'b1, 1'(i_tv_encoder_model.odd_cnt >= 2))
      `CHK("even starts", 1'b1, 1'(i_tv_encoder_model.even_cnt >= 1))
      `CHK("odd flag", 1'b1, odd_field)
      enable = 1'b0;
      // the port runs on to the end of the even field, then falls quiet
      repeat (1500) @(posedge mclk);
      quiet = 1'b1;
      for (int i = 0; i < 200; i++) begin
         @(posedge mclk);
         #2;
         quiet = quiet && tv_line_sync_n && tv_field_sync_n && tv_data_valid_n;
      end
      `CHK("stop quiet", 1'b1, quiet)
      $display("t_fields done");
   endtask : t_fields
   initial begin
      repeat (8) @(posedge mclk);
      #2;
      rstn = 1'b1;
      repeat (4) @(posedge mclk);
      #2;
      t_reset();
      t_fill_stream();
      t_fields();
      wrap_up();
   end
endmodule : tv_encoder_out_bench
